// ===== verilog/time_unit_pkg.sv
// Shared constants and types of the network time stamp unit
package time_unit_pkg;
    // Time base and clock
    localparam int TIME_W = 32;
    localparam int CLK_PERIOD_NS = 25;
    localparam int US_NS = 1000;
    localparam int US_TICK_CYCLES = US_NS / CLK_PERIOD_NS;
    // Start-of-cycle frame trails the system tick by this many microseconds
    localparam int SOC_DELAY_US = 20;
    localparam logic [31:0] SOC_DELAY = 32'h0000_0014;
    // Reset values
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_DIFF = 32'h0000_0000;
    // Which network the reference time comes from
    typedef enum logic {
        NET_BACKPLANE,
        NET_REALTIME_ETH
    } net_src_t;
    // Timed output scheduler states
    typedef enum logic {
        OUT_IDLE,
        OUT_ARMED
    } out_state_t;
    // Measurement states
    typedef enum logic {
        MEAS_IDLE,
        MEAS_RUN
    } meas_state_t;
endpackage

// ===== verilog/time_bus_if.sv
// Carries corrected network time from the time base to its stamping units
`timescale 1ns/1ps
interface time_bus_if;
    logic [31:0] network_time;
    modport src (output network_time);
    modport dst (input network_time);
endinterface

// ===== verilog/edge_stamp.sv
// Timed input: stamps input edges with network time and measures spans
`timescale 1ns/1ps
module edge_stamp
    import time_unit_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Time from the time base
    time_bus_if.dst tb,
    // Input pin and option
    input wire logic in_pin,
    input wire logic fall_en,
    // Stamp results
    output logic stamp_valid,
    output logic [31:0] stamp_time,
    output logic stamp_rise,
    output logic [31:0] span_time
);
    logic pin_q, pin_d;
    logic valid_q, valid_d;
    logic rise_q, rise_d;
    logic [31:0] time_q, time_d;
    logic [31:0] span_q, span_d;
    logic have_q, have_d;
    logic rise_ev, fall_ev;

    // Edge detection on the sampled pin
    assign rise_ev = in_pin && !pin_q;
    assign fall_ev = !in_pin && pin_q && fall_en;

    // Next stamp; span is the gap to the previous stamped event
    always_comb begin
        pin_d = in_pin;
        valid_d = 1'b0;
        rise_d = rise_q;
        time_d = time_q;
        span_d = span_q;
        have_d = have_q;
        if (rise_ev || fall_ev) begin
            valid_d = 1'b1;
            rise_d = rise_ev;
            time_d = tb.network_time;
            have_d = 1'b1;
            if (have_q) begin
                span_d = tb.network_time - time_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_q <= 1'b0;
            valid_q <= 1'b0;
            rise_q <= 1'b0;
            time_q <= TIME_RST;
            span_q <= TIME_RST;
            have_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            valid_q <= valid_d;
            rise_q <= rise_d;
            time_q <= time_d;
            span_q <= span_d;
            have_q <= have_d;
        end
    end

    assign stamp_valid = valid_q;
    assign stamp_time = time_q;
    assign stamp_rise = rise_q;
    assign span_time = span_q;

    AST_EDGE_STAMP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rise_ev |=> stamp_valid && stamp_rise && stamp_time == $past(tb.network_time))
        else $error("rising edge not stamped with current time");
    AST_FALL_GATED: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!in_pin && pin_q && !fall_en) |=> !stamp_valid)
        else $error("falling edge stamped while disabled");
    COV_SPAN: cover property (@(posedge clk_sys) disable iff (!rst_b)
        have_q && rise_ev ##[1:200] fall_ev);
endmodule

// ===== verilog/network_time_unit.sv
// Microsecond network time base with offset correction, stamping and scheduling
`timescale 1ns/1ps
// How it works
// - 32-bit time counters advance each microsecond and wrap freely.
// - Counters start from the controller's system time at link startup.
// - Time is latched into a holding register on every system clock tick.
// - Backplane reference time sits at the link cycle's midpoint.
// - Real-time Ethernet reference time sits at the cycle frame, 20 us after tick.
// - That reference equals system time minus cycle time plus 20 us.
// - Each update except startup stores received time minus the local counter as difference.
// - Event time is local counter plus the stored difference.
// - A timestamp event captures network time at once for delivery.
// - Inputs stamp rising and optionally falling edges, and report spans.
// - Outputs switch at requested network times, forming pulse patterns.
// - Measurements capture both start and end moments for transfer.
module network_time_unit
    import time_unit_pkg::*;
#(
    parameter int TICK_CYCLES = US_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Time update from the controller, one per link cycle
    input wire logic upd_valid,
    input wire logic upd_start,
    input wire logic [31:0] upd_time,
    input wire logic net_sel,
    input wire logic [31:0] cycle_us,
    // System clock tick and held time
    input wire logic sys_tick,
    output logic [31:0] held_time,
    output logic [31:0] network_time,
    // Timed input
    input wire logic in_pin,
    input wire logic in_fall_en,
    output logic in_stamp_valid,
    output logic [31:0] in_stamp_time,
    output logic in_stamp_rise,
    output logic [31:0] in_span_time,
    // Timed output requests
    input wire logic out_req_valid,
    output logic out_req_ready,
    input wire logic [31:0] out_req_time,
    input wire logic out_req_level,
    output logic out_pin,
    // Timed measurement
    input wire logic meas_start,
    input wire logic meas_end,
    output logic meas_done,
    output logic [31:0] meas_start_time,
    output logic [31:0] meas_end_time
);
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

    time_bus_if tb ();

    logic [7:0] pre_q, pre_d;
    // Cycles since the last tick, kept only for the period check
    logic [7:0] since_q, since_d;
    logic us_tick;
    logic [31:0] local_q, local_d;
    logic [31:0] diff_q, diff_d;
    logic [31:0] net_q, net_d;
    logic [31:0] held_q, held_d;
    logic [31:0] ref_time;

    // Signed distance from now to a target; negative or zero means reached
    function automatic logic is_due(input logic [31:0] target, input logic [31:0] now);
        logic [31:0] gap;
        gap = target - now;
        is_due = gap[31] || (gap == ZERO_DIFF);
    endfunction

    // Reference time of the incoming update; the update arrives at cycle start
    always_comb begin
        if (net_sel == NET_REALTIME_ETH) begin
            ref_time = upd_time - cycle_us + SOC_DELAY;
        end else begin
            ref_time = upd_time - {1'b0, cycle_us[31:1]};
        end
    end

    // Microsecond prescaler from the system clock
    always_comb begin
        since_d = since_q + 8'h01;
        if (pre_q == TICK_LAST) begin
            pre_d = 8'h00;
            since_d = 8'h00;
        end else begin
            pre_d = pre_q + 8'h01;
        end
    end
    assign us_tick = (pre_q == TICK_LAST);

    // Local counter and stored difference; wrap is intended, values are relative
    always_comb begin
        local_d = local_q;
        diff_d = diff_q;
        if (us_tick) begin
            local_d = local_q + 32'h0000_0001;
        end
        if (upd_valid && upd_start) begin
            // Startup loads the counter directly, so no difference is left
            local_d = ref_time;
            diff_d = ZERO_DIFF;
        end else if (upd_valid) begin
            // Updates come once per link cycle from the controller
            diff_d = ref_time - local_q;
        end
        net_d = local_d + diff_d;
    end

    // Holding register for reads, refreshed at every system tick
    always_comb begin
        held_d = held_q;
        if (sys_tick) begin
            held_d = net_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pre_q <= 8'h00;
            since_q <= 8'h00;
            local_q <= TIME_RST;
            diff_q <= ZERO_DIFF;
            net_q <= TIME_RST;
            held_q <= TIME_RST;
        end else begin
            pre_q <= pre_d;
            since_q <= since_d;
            local_q <= local_d;
            diff_q <= diff_d;
            net_q <= net_d;
            held_q <= held_d;
        end
    end

    assign tb.network_time = net_q;
    assign held_time = held_q;
    assign network_time = net_q;

    // Timed input stamping
    edge_stamp u_edge_stamp (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tb(tb),
        .in_pin(in_pin),
        .fall_en(in_fall_en),
        .stamp_valid(in_stamp_valid),
        .stamp_time(in_stamp_time),
        .stamp_rise(in_stamp_rise),
        .span_time(in_span_time)
    );

    // Timed output: one pending edge at a time, the controller feeds the next
    out_state_t ost_q, ost_d;
    logic [31:0] tgt_q, tgt_d;
    logic lvl_q, lvl_d;
    logic pin_q, pin_d;
    logic out_fire;

    assign out_req_ready = (ost_q == OUT_IDLE);
    assign out_fire = (ost_q == OUT_ARMED) && is_due(tgt_q, net_q);

    // A target already past fires at once; the controller keeps them ahead
    always_comb begin
        ost_d = ost_q;
        tgt_d = tgt_q;
        lvl_d = lvl_q;
        pin_d = pin_q;
        case (ost_q)
            OUT_IDLE: begin
                if (out_req_valid) begin
                    tgt_d = out_req_time;
                    lvl_d = out_req_level;
                    ost_d = OUT_ARMED;
                end
            end
            OUT_ARMED: begin
                if (out_fire) begin
                    pin_d = lvl_q;
                    ost_d = OUT_IDLE;
                end
            end
            default: begin
                ost_d = OUT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ost_q <= OUT_IDLE;
            tgt_q <= TIME_RST;
            lvl_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            ost_q <= ost_d;
            tgt_q <= tgt_d;
            lvl_q <= lvl_d;
            pin_q <= pin_d;
        end
    end

    assign out_pin = pin_q;

    // Measurement window: start moment kept until the end moment arrives
    meas_state_t mst_q, mst_d;
    logic [31:0] mstart_q, mstart_d;
    logic [31:0] mend_q, mend_d;
    logic mdone_q, mdone_d;

    always_comb begin
        mst_d = mst_q;
        mstart_d = mstart_q;
        mend_d = mend_q;
        mdone_d = 1'b0;
        case (mst_q)
            MEAS_IDLE: begin
                if (meas_start) begin
                    mstart_d = net_q;
                    mst_d = MEAS_RUN;
                end
            end
            MEAS_RUN: begin
                if (meas_end) begin
                    mend_d = net_q;
                    mdone_d = 1'b1;
                    mst_d = MEAS_IDLE;
                end
            end
            default: begin
                mst_d = MEAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mst_q <= MEAS_IDLE;
            mstart_q <= TIME_RST;
            mend_q <= TIME_RST;
            mdone_q <= 1'b0;
        end else begin
            mst_q <= mst_d;
            mstart_q <= mstart_d;
            mend_q <= mend_d;
            mdone_q <= mdone_d;
        end
    end

    assign meas_done = mdone_q;
    assign meas_start_time = mstart_q;
    assign meas_end_time = mend_q;

    // Checks on the time base and its users
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_US_ADVANCE: assert property (
        (us_tick && !upd_valid) |=> local_q == $past(local_q) + 32'h0000_0001)
        else $error("local counter did not advance on microsecond tick");
    // Period follows the parameter, so a fast simulation setting stays legal
    AST_US_PERIOD: assert property (
        us_tick == (since_q == TICK_LAST))
        else $error("microsecond tick period wrong");
    AST_START_LOAD: assert property (
        (upd_valid && upd_start) |=> net_q == $past(ref_time) && diff_q == ZERO_DIFF)
        else $error("startup did not load time from controller");
    AST_HOLD: assert property (
        sys_tick |=> held_time == $past(net_q))
        else $error("held time not latched at system tick");
    AST_BP_REF: assert property (
        (upd_valid && net_sel == NET_BACKPLANE) |-> ref_time == upd_time - (cycle_us >> 1))
        else $error("backplane reference not at cycle midpoint");
    AST_RT_REF: assert property (
        (upd_valid && net_sel == NET_REALTIME_ETH) |-> ref_time + cycle_us == upd_time + SOC_DELAY)
        else $error("realtime reference time wrong");
    AST_DIFF: assert property (
        (upd_valid && !upd_start) |=> diff_q == $past(ref_time) - $past(local_q))
        else $error("difference not stored on update");
    AST_CORRECT: assert property (
        net_q == local_q + diff_q)
        else $error("network time is not local plus difference");
    AST_FIRE: assert property (
        (ost_q == OUT_ARMED && is_due(tgt_q, net_q)) |=> out_pin == $past(lvl_q) && out_req_ready)
        else $error("output edge not driven when due");
    AST_NOT_EARLY: assert property (
        (ost_q == OUT_ARMED && !is_due(tgt_q, net_q)) |=> $stable(out_pin) && !out_req_ready)
        else $error("output edge driven early");
    AST_MEAS: assert property (
        (mst_q == MEAS_RUN && meas_end) |=> meas_done && meas_end_time == $past(net_q))
        else $error("measurement end not captured");
    AST_MEAS_IDLE: assert property (
        (mst_q == MEAS_IDLE && meas_end) |=> !meas_done)
        else $error("measurement ended while idle");

    COV_UPDATE_RT: cover property (upd_valid && net_sel == NET_REALTIME_ETH && !upd_start);
    COV_PULSE: cover property (out_fire && lvl_q ##[1:500] out_fire && !lvl_q);
    COV_MEAS: cover property (mst_q == MEAS_RUN && meas_end);
    COV_WRAP: cover property (net_q == 32'hFFFF_FFFF ##[1:60] net_q == 32'h0000_0000);
endmodule

// ===== tb/link_ctrl_model.sv
// Behavioural controller that owns system time and sends link time updates
`timescale 1ns/1ps
module link_ctrl_model #(
    parameter int TICK = 4,
    parameter int LINK_CLKS = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Control from the bench
    input wire logic link_on,
    input wire logic link_start,
    input wire logic set_en,
    input wire logic [31:0] set_val,
    // Link side towards the module
    output logic upd_valid,
    output logic upd_start,
    output logic [31:0] upd_time,
    output logic sys_tick
);
    int pre = 1;
    int lc = 1;
    logic [31:0] sys_us = 32'h0000_61A8;
    initial begin
        upd_valid = 1'b0;
        upd_start = 1'b0;
        upd_time = 32'h0000_0000;
        sys_tick = 1'b0;
    end
    // Outputs move by non-blocking assignment so the bench never races them
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            lc = 1;
            sys_tick <= 1'b0;
            upd_valid <= 1'b0;
        end else begin
            // Own microsecond count, out of phase with the module on purpose
            if (set_en)
                sys_us = set_val;
            else if (pre == TICK - 1)
                sys_us = sys_us + 32'h1;
            pre = (pre + 1) % TICK;
            lc = (lc + 1) % LINK_CLKS;
            sys_tick <= (lc == 0);
            upd_valid <= (lc == 0) && link_on;
            upd_start <= link_start; // Left up between updates to test that it is ignored
            // Idle bus never keeps the last time value
            upd_time <= ((lc == 0) && link_on) ? sys_us : ~upd_time;
        end
    end
endmodule

// ===== tb/network_time_timestamp_unit_test.sv
// Self-checking bench of the network time unit against a controller model
`timescale 1ns/1ps
module network_time_timestamp_unit_test;
    import time_unit_pkg::*;
    localparam int TICK = 4;
    logic clk_sys, rst_b, net_sel, in_pin, in_fall_en, out_req_valid, out_req_level;
    logic meas_start, meas_end, link_on, link_start, set_en;
    logic [31:0] cycle_us, out_req_time, set_val;
    logic upd_valid, upd_start, sys_tick, in_stamp_valid, in_stamp_rise, out_req_ready, out_pin, meas_done;
    logic [31:0] upd_time, held_time, network_time, in_stamp_time, in_span_time, meas_start_time, meas_end_time;
    int errors = 0;
    int n_checks = 0;

    // Short microsecond so long waits stay cheap
    network_time_unit #(.TICK_CYCLES(TICK)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .upd_valid(upd_valid),
        .upd_start(upd_start), .upd_time(upd_time), .net_sel(net_sel), .cycle_us(cycle_us),
        .sys_tick(sys_tick), .held_time(held_time), .network_time(network_time), .in_pin(in_pin),
        .in_fall_en(in_fall_en), .in_stamp_valid(in_stamp_valid), .in_stamp_time(in_stamp_time),
        .in_stamp_rise(in_stamp_rise), .in_span_time(in_span_time), .out_req_valid(out_req_valid),
        .out_req_ready(out_req_ready), .out_req_time(out_req_time), .out_req_level(out_req_level),
        .out_pin(out_pin), .meas_start(meas_start), .meas_end(meas_end), .meas_done(meas_done),
        .meas_start_time(meas_start_time), .meas_end_time(meas_end_time));
    link_ctrl_model #(.TICK(TICK), .LINK_CLKS(32)) ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
        .link_on(link_on), .link_start(link_start), .set_en(set_en), .set_val(set_val),
        .upd_valid(upd_valid), .upd_start(upd_start), .upd_time(upd_time), .sys_tick(sys_tick));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // A tick may land on the update edge, so one extra microsecond is allowed
    task check_near(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp && got !== exp + 32'h1) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check1(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task stop_test;
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One link update; returns the reference time it should carry
    task send_update(input logic start, input logic sel, input logic [31:0] cyc, output logic [31:0] r);
        int i;
        net_sel = sel;
        cycle_us = cyc;
        link_start = start;
        link_on = 1'b1;
        i = 0;
        while (upd_valid !== 1'b1 && i < 200) begin
            step(1);
            i++;
        end
        check1("update seen", 1'b1, upd_valid);
        link_on = 1'b0;
        r = sel ? upd_time - cyc + SOC_DELAY : upd_time - (cyc >> 1);
        step(1);
    endtask
    task t_startup;
        logic [31:0] r, n0;
        send_update(1'b1, 1'b0, 32'h0000_07D0, r);
        check_near("startup time", r, network_time);
        n0 = network_time;
        step(10 * TICK);
        check32("ten microseconds", n0 + 32'hA, network_time);
    endtask
    task t_realtime;
        logic [31:0] r;
        send_update(1'b0, 1'b1, 32'h0000_07D0, r);
        check_near("soc reference", r, network_time);
        step(8 * TICK);
        check_near("corrected time", r + 32'h8, network_time);
    endtask
    task t_held;
        logic [31:0] t;
        int i;
        i = 0;
        while (sys_tick !== 1'b1 && i < 100) begin
            step(1);
            i++;
        end
        check1("tick seen", 1'b1, sys_tick);
        t = network_time;
        step(1);
        check32("held time", t, held_time);
    endtask
    task t_input;
        logic [31:0] t1, t2;
        in_fall_en = 1'b1;
        in_pin = 1'b1;
        t1 = network_time;
        step(1);
        check1("rise stamp", 1'b1, in_stamp_valid);
        check1("rise flag", 1'b1, in_stamp_rise);
        check32("rise time", t1, in_stamp_time);
        step(6);
        in_pin = 1'b0;
        t2 = network_time;
        step(1);
        check1("fall stamp", 1'b1, in_stamp_valid);
        check1("fall flag", 1'b0, in_stamp_rise);
        check32("fall time", t2, in_stamp_time);
        check32("span", t2 - t1, in_span_time);
        in_fall_en = 1'b0;
        in_pin = 1'b1;
        step(4);
        in_pin = 1'b0;
        step(1);
        check1("fall ignored", 1'b0, in_stamp_valid);
    endtask
    // Schedules one output edge and watches it land on its microsecond
    task sched_edge(input logic lvl, input logic [31:0] ahead);
        logic [31:0] tgt;
        int i;
        tgt = network_time + ahead;
        out_req_time = tgt;
        out_req_level = lvl;
        out_req_valid = 1'b1;
        i = 0;
        while (out_req_ready !== 1'b1 && i < 100) begin
            step(1);
            i++;
        end
        check1("ready for request", 1'b1, out_req_ready);
        step(1);
        out_req_valid = 1'b0;
        check1("ready while armed", 1'b0, out_req_ready);
        i = 0;
        while (network_time !== tgt && i < 1000) begin
            check1("pin early", ~lvl, out_pin);
            step(1);
            i++;
        end
        check32("target reached", tgt, network_time);
        check1("pin before target", ~lvl, out_pin);
        step(1);
        check1("pin at target", lvl, out_pin);
        check1("ready after fire", 1'b1, out_req_ready);
    endtask
    task t_wrap;
        logic [31:0] r;
        set_val = 32'hFFFF_FFF0;
        set_en = 1'b1;
        step(1);
        set_en = 1'b0;
        send_update(1'b1, 1'b0, 32'h0000_0000, r);
        check_near("wrap start", r, network_time);
        sched_edge(1'b1, 32'h0000_0020);
    endtask
    task t_meas;
        logic [31:0] ts, te;
        meas_end = 1'b1;
        step(1);
        meas_end = 1'b0;
        check1("end while idle", 1'b0, meas_done);
        step(1);
        meas_start = 1'b1;
        ts = network_time;
        step(1);
        meas_start = 1'b0;
        step(6);
        meas_end = 1'b1;
        te = network_time;
        step(1);
        meas_end = 1'b0;
        check1("measure done", 1'b1, meas_done);
        check32("measure start", ts, meas_start_time);
        check32("measure end", te, meas_end_time);
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #(25 * 20000);
        errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        {rst_b, net_sel, in_pin, in_fall_en, out_req_valid, out_req_level} = 6'h00;
        {meas_start, meas_end, link_on, link_start, set_en} = 5'h00;
        cycle_us = 32'h0000_0000;
        out_req_time = 32'h0000_0000;
        set_val = 32'h0000_0000;
        step(20);
        rst_b = 1'b1;
        step(2);
        t_startup();
        t_realtime();
        t_held();
        t_input();
        // Targets stay more than one model link cycle (8 us) ahead
        sched_edge(1'b1, 32'h0000_0009);
        sched_edge(1'b0, 32'h0000_000C);
        t_meas();
        t_wrap();
        stop_test();
    end
endmodule
